//--- src/bcps_pkg.sv
// Package: constants and carriers for the bus clock phase sampler
// Contract
// - Present 32-bit address, move 32-bit data
// - Drive start, type, space, size controls
// - Processor clock is twice bus clock; here i_mclk runs at four times the bus clock, one phase state per i_mclk cycle
// - Bus timing ignores processor clock edges
// - All bus events reference bus rising edge
// - Four phase states per bus clock
// - Most outputs change in fourth phase
// - Three strobes float in first phase
// - Synchronous inputs sampled on bus rise
// - Interrupt level, reset in get synchronised
package bcps_pkg;
  localparam int unsigned MCLK_MHZ = 100;
  localparam int unsigned PHASE_COUNT = 4;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_FOURTH = 2'h3;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned IPL_W = 3;
  localparam logic [IPL_W-1:0] IPL_RST = 3'h7;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [1:0] SIZE_LONG = 2'h0;

  typedef enum logic [1:0] {
    BCPS_P1 = 2'b00,
    BCPS_P2 = 2'b01,
    BCPS_P3 = 2'b10,
    BCPS_P4 = 2'b11
  } bcps_phase_t;

  // One bus request from the core
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic [1:0] size;
    logic [1:0] ttype;
    logic [2:0] space;
  } bcps_req_t;

  // Synchronous bus inputs
  typedef struct packed {
    logic [31:0] rdata;
    logic ack_n;
    logic err_n;
  } bcps_bin_t;
endpackage

//--- src/bcps_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module bcps_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_en,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Both stages advance only on bus clock rises
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= RST;
      sync_q <= RST;
    end else if (i_en) begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule
`default_nettype wire

//--- src/bcps_top.sv
// Bus clock phase sampler: phase states, bus drive and input sampling
`timescale 1ns/10ps
`default_nettype none
module bcps_top (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_bclk,
  input wire bcps_pkg::bcps_req_t i_req,
  input wire logic i_req_valid,
  input wire bcps_pkg::bcps_bin_t i_bus_in,
  input wire logic [2:0] i_interrupt_level_n,
  input wire logic i_reset_in_n,
  input wire logic i_ack_drive,
  output logic o_req_ready,
  output logic o_done,
  output logic o_error,
  output logic [31:0] o_rdata,
  output logic [31:0] o_addr,
  output logic [31:0] o_data,
  output logic o_data_oe_n,
  output logic o_start_n,
  output logic o_write,
  output logic [1:0] o_size,
  output logic [1:0] o_ttype,
  output logic [2:0] o_space,
  output logic o_addr_oe_n,
  output logic o_transfer_in_progress_n,
  output logic o_transfer_in_progress_oe_n,
  output logic o_transfer_ack_n,
  output logic o_transfer_ack_oe_n,
  output logic o_bus_busy_n,
  output logic o_bus_busy_oe_n,
  output logic [2:0] o_interrupt_level_n,
  output logic o_reset_in_n,
  output bcps_pkg::bcps_phase_t o_phase
);
  // i_mclk stands in for the processor clock; bus clock is a pin input
  logic bclk_m_q, bclk_s_q, bclk_p_q;
  logic brise;
  bcps_pkg::bcps_phase_t phase_q, phase_d;
  logic enter_p4, enter_p1;

  // Bus clock pin passes two flops before use
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bclk_m_q <= 1'b0;
      bclk_s_q <= 1'b0;
      bclk_p_q <= 1'b0;
    end else begin
      bclk_m_q <= i_bclk;
      bclk_s_q <= bclk_m_q;
      bclk_p_q <= bclk_s_q;
    end
  end
  assign brise = bclk_s_q & ~bclk_p_q;

  // Phase counter locked to the bus rising edge, two core cycles per half
  always_comb begin
    if (brise) begin
      phase_d = bcps_pkg::BCPS_P1;
    end else begin
      case (phase_q)
        bcps_pkg::BCPS_P1: phase_d = bcps_pkg::BCPS_P2;
        bcps_pkg::BCPS_P2: phase_d = bcps_pkg::BCPS_P3;
        bcps_pkg::BCPS_P3: phase_d = bcps_pkg::BCPS_P4;
        bcps_pkg::BCPS_P4: phase_d = bcps_pkg::BCPS_P4;
        default: phase_d = bcps_pkg::BCPS_P1;
      endcase
    end
  end
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_q <= bcps_pkg::BCPS_P1;
    end else begin
      phase_q <= phase_d;
    end
  end
  assign o_phase = phase_q;
  assign enter_p4 = (phase_d == bcps_pkg::BCPS_P4) && (phase_q != bcps_pkg::BCPS_P4);
  assign enter_p1 = brise;

  // Core cycles since the last bus rise; a drifting bus clock trips the ratio check
  logic [2:0] per_cnt_q;
  logic per_seen_q;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      per_cnt_q <= 3'h0;
      per_seen_q <= 1'h0;
    end else if (brise) begin
      per_cnt_q <= 3'h1;
      per_seen_q <= 1'h1;
    end else if (per_cnt_q != 3'h7) begin
      per_cnt_q <= per_cnt_q + 3'h1;
    end
  end
  a_clock_ratio: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (brise && per_seen_q) |-> (per_cnt_q == 3'(bcps_pkg::PHASE_COUNT)))
    else $error("bus period is not four phase states");

  // Asynchronous inputs: sampled and synchronised on bus rises only
  bcps_sync #(.W(bcps_pkg::IPL_W), .RST(bcps_pkg::IPL_RST)) u_ipl_sync (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_en(brise),
    .i_async(i_interrupt_level_n),
    .o_sync(o_interrupt_level_n)
  );
  bcps_sync #(.W(1), .RST(1'b0)) u_rst_sync (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_en(brise),
    .i_async(i_reset_in_n),
    .o_sync(o_reset_in_n)
  );

  // Synchronised level copy moves only on a bus rise
  a_ipl_sync: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_interrupt_level_n) |-> $past(brise)) else $error("level copy changed off bus rise");

  // Synchronous bus inputs: two flops for the pin crossing, then bus-rise capture
  bcps_pkg::bcps_bin_t bin_m_q, bin_s_q, bin_q;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bin_m_q <= '1;
      bin_s_q <= '1;
      bin_q <= '1;
    end else begin
      bin_m_q <= i_bus_in;
      bin_s_q <= bin_m_q;
      if (brise) begin
        bin_q <= bin_s_q;
      end
    end
  end

  // Cycle sequencer: idle, start, wait for termination, finish
  typedef enum logic [1:0] {
    BCPS_IDLE = 2'b00,
    BCPS_START = 2'b01,
    BCPS_WAIT = 2'b10,
    BCPS_END = 2'b11
  } bcps_state_t;
  bcps_state_t st_q;
  bcps_pkg::bcps_req_t req_q;
  logic term_seen;
  assign term_seen = brise && (st_q == BCPS_WAIT) && (!bin_s_q.ack_n || !bin_s_q.err_n);

  // State changes only on bus rises, never on bare core edges
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= BCPS_IDLE;
    end else if (brise) begin
      case (st_q)
        BCPS_IDLE: if (i_req_valid) st_q <= BCPS_START;
        BCPS_START: st_q <= BCPS_WAIT;
        BCPS_WAIT: if (term_seen) st_q <= BCPS_END;
        BCPS_END: st_q <= BCPS_IDLE;
        default: st_q <= BCPS_IDLE;
      endcase
    end
  end

  // Request captured at bus rise when idle
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_q <= '0;
    end else if (brise && st_q == BCPS_IDLE && i_req_valid) begin
      req_q <= i_req;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_req_ready <= 1'b0;
    end else begin
      o_req_ready <= (st_q == BCPS_IDLE) && !(brise && i_req_valid);
    end
  end
  // No second request is invited while a cycle runs
  a_ready_idle: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_req_ready |-> ($past(st_q) == BCPS_IDLE)) else $error("ready shown while busy");

  // Completion pulse and read data
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_done <= 1'b0;
      o_error <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else begin
      o_done <= term_seen;
      o_error <= term_seen && !bin_s_q.err_n;
      if (term_seen && !req_q.write) begin
        o_rdata <= bin_s_q.rdata;
      end
    end
  end
  // Completion is a single pulse, error rides on it
  a_done_pulse: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_done |=> !o_done) else $error("done longer than one cycle");
  a_error_done: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_error |-> o_done) else $error("error without done");
  a_rdata_term: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_rdata) |-> $past(term_seen)) else $error("read data moved without termination");

  // Address, data and controls change only on entering the fourth phase
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_addr <= bcps_pkg::ADDR_RST;
      o_data <= 32'h0000_0000;
      o_data_oe_n <= 1'b1;
      o_addr_oe_n <= 1'b1;
      o_start_n <= 1'b1;
      o_write <= 1'b0;
      o_size <= bcps_pkg::SIZE_LONG;
      o_ttype <= 2'h0;
      o_space <= 3'h0;
    end else if (enter_p4) begin
      o_start_n <= !(st_q == BCPS_START);
      o_addr_oe_n <= (st_q == BCPS_IDLE);
      o_data_oe_n <= !((st_q == BCPS_START || st_q == BCPS_WAIT) && req_q.write);
      if (st_q == BCPS_START) begin
        o_addr <= req_q.addr;
        o_data <= req_q.wdata;
        o_write <= req_q.write;
        o_size <= req_q.size;
        o_ttype <= req_q.ttype;
        o_space <= req_q.space;
      end
    end
  end
  // Data, enables and controls only move in the fourth phase
  a_data_fourth: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_data) |-> (phase_q == bcps_pkg::BCPS_P4)) else $error("data moved outside fourth phase");
  a_oe_fourth: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed({o_addr_oe_n, o_data_oe_n}) |-> (phase_q == bcps_pkg::BCPS_P4))
    else $error("enable moved outside fourth phase");
  a_ctl_fourth: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed({o_write, o_size, o_ttype, o_space}) |-> (phase_q == bcps_pkg::BCPS_P4))
    else $error("controls moved outside fourth phase");

  // Strobes: level in fourth phase, release to float at first phase
  logic xfer_busy;
  assign xfer_busy = (st_q == BCPS_START) || (st_q == BCPS_WAIT);
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_transfer_in_progress_n <= 1'b1;
      o_transfer_in_progress_oe_n <= 1'b1;
      o_bus_busy_n <= 1'b1;
      o_bus_busy_oe_n <= 1'b1;
      o_transfer_ack_n <= 1'b1;
      o_transfer_ack_oe_n <= 1'b1;
    end else if (enter_p4) begin
      o_transfer_in_progress_n <= !xfer_busy;
      o_bus_busy_n <= !xfer_busy;
      o_transfer_ack_n <= !(i_ack_drive && xfer_busy);
      if (xfer_busy) begin
        o_transfer_in_progress_oe_n <= 1'b0;
        o_bus_busy_oe_n <= 1'b0;
      end
      if (i_ack_drive) begin
        o_transfer_ack_oe_n <= 1'b0;
      end
    end else if (enter_p1) begin
      // Negate first, float a phase later so the line is not left low
      if (o_transfer_in_progress_n) o_transfer_in_progress_oe_n <= 1'b1;
      if (o_bus_busy_n) o_bus_busy_oe_n <= 1'b1;
      if (o_transfer_ack_n) o_transfer_ack_oe_n <= 1'b1;
    end
  end

  // Strobe checks: level in fourth phase, drive in fourth, float in first
  a_ta_float: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_transfer_ack_oe_n) |-> (phase_q == bcps_pkg::BCPS_P1)) else $error("ack floated outside first phase");
  a_ta_level: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_transfer_ack_n) |-> (phase_q == bcps_pkg::BCPS_P4)) else $error("ack level outside fourth phase");
  a_bb_float: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_bus_busy_oe_n) |-> (phase_q == bcps_pkg::BCPS_P1)) else $error("busy floated outside first phase");
  a_bb_level: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_bus_busy_n) |-> (phase_q == bcps_pkg::BCPS_P4)) else $error("busy level outside fourth phase");
  a_tip_drive: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $fell(o_transfer_in_progress_oe_n) |-> (phase_q == bcps_pkg::BCPS_P4))
    else $error("tip driven outside fourth phase");
  a_bb_drive: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $fell(o_bus_busy_oe_n) |-> (phase_q == bcps_pkg::BCPS_P4)) else $error("busy driven outside fourth phase");

  // Checks
  a_phase_reset: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    brise |=> (phase_q == bcps_pkg::BCPS_P1)) else $error("phase not first after bus rise");
  a_phase_step: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (!brise && phase_q == bcps_pkg::BCPS_P1) |=> (phase_q == bcps_pkg::BCPS_P2)) else $error("phase did not step");
  a_addr_fourth: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_addr) |-> (phase_q == bcps_pkg::BCPS_P4)) else $error("address moved outside fourth phase");
  a_start_fourth: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_start_n) |-> (phase_q == bcps_pkg::BCPS_P4)) else $error("start moved outside fourth phase");
  a_tip_float: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_transfer_in_progress_oe_n) |-> (phase_q == bcps_pkg::BCPS_P1)) else $error("tip floated outside first phase");
  a_tip_level: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_transfer_in_progress_n) |-> (phase_q == bcps_pkg::BCPS_P4)) else $error("tip level outside fourth phase");
  a_state_bus: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !brise |=> $stable(st_q)) else $error("state changed without bus rise");
  a_done_term: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_done |-> $past(st_q) == BCPS_WAIT && $past(brise)) else $error("done without termination");
  a_sample_rise: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(bin_q) |-> $past(brise)) else $error("input sampled off bus rise");
  a_rst_sync: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_reset_in_n) |-> $past(brise)) else $error("reset in changed off bus rise");
endmodule
`default_nettype wire

//--- verif/bcps_slave.sv
// Bus slave model that terminates each cycle after a set wait
`timescale 1ns/10ps
`default_nettype none
module bcps_slave (
  input wire logic i_bclk,
  input wire logic i_start_n,
  input wire logic [3:0] i_waits,
  input wire logic i_err,
  input wire logic [31:0] i_rdata,
  output bcps_pkg::bcps_bin_t o_bus_in
);
  int cnt = -1;
  initial o_bus_in = {32'h0, 2'h3};
  // Moves only after a bus rise, then holds a whole period
  always @(posedge i_bclk) begin
    o_bus_in.ack_n <= 1'h1;
    o_bus_in.err_n <= 1'h1;
    // Released data bus shows a changing pattern
    o_bus_in.rdata <= ~o_bus_in.rdata;
    if (!i_start_n) begin
      cnt <= i_waits;
    end else if (cnt == 0) begin
      o_bus_in.ack_n <= i_err;
      o_bus_in.err_n <= !i_err;
      o_bus_in.rdata <= i_rdata;
    end
    if (cnt >= 0 && i_start_n) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

//--- verif/bcps_top_tb.sv
// Self-checking bench for the bus clock phase sampler
`timescale 1ns/10ps
`default_nettype none
module bcps_top_tb;
  logic mclk, rst_n, bclk, vld, rin_n, err_i, rdy, done, err, doe_n, st_n, wr, ackd;
  logic aoe_n, tip_n, tip_oe_n, ta_n, ta_oe_n, bb_n, bb_oe_n, rsi_n;
  logic [1:0] div, size, ttype;
  logic [2:0] ipl_n, space, ipl_s;
  logic [3:0] waits;
  logic [31:0] rd, rdata, addr, data;
  bcps_pkg::bcps_req_t req;
  bcps_pkg::bcps_bin_t bin;
  bcps_pkg::bcps_phase_t ph;
  int errors = 0;
  int cmp_count = 0;
  // Slow bus clock keeps all four phase states visible past the synchroniser
  assign bclk = div[1];
  always @(negedge mclk) div <= div + 2'h1;
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  bcps_top bcps_top_inst (.i_mclk(mclk), .i_reset_n(rst_n), .i_bclk(bclk),
    .i_req(req), .i_req_valid(vld), .i_bus_in(bin), .i_interrupt_level_n(ipl_n),
    .i_reset_in_n(rin_n), .i_ack_drive(ackd), .o_req_ready(rdy), .o_done(done),
    .o_error(err), .o_rdata(rdata), .o_addr(addr), .o_data(data), .o_data_oe_n(doe_n),
    .o_start_n(st_n), .o_write(wr), .o_size(size), .o_ttype(ttype), .o_space(space),
    .o_addr_oe_n(aoe_n), .o_transfer_in_progress_n(tip_n),
    .o_transfer_in_progress_oe_n(tip_oe_n), .o_transfer_ack_n(ta_n),
    .o_transfer_ack_oe_n(ta_oe_n), .o_bus_busy_n(bb_n), .o_bus_busy_oe_n(bb_oe_n),
    .o_interrupt_level_n(ipl_s), .o_reset_in_n(rsi_n), .o_phase(ph));
  bcps_slave bcps_slave_inst (.i_bclk(bclk), .i_start_n(st_n), .i_waits(waits),
    .i_err(err_i), .i_rdata(rd), .o_bus_in(bin));
  task automatic end_sim();
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // Bounded wait; a hang ends the run
  task automatic waitv(ref logic s, input logic v, output int n);
    for (n = 0; n < 400 && s !== v; n++) @(negedge mclk);
    if (s !== v) begin
      errors++;
      $display("CHECK FAILED timeout exp %h got %h", v, s);
      end_sim();
    end
  endtask
  task automatic t_sync();
    int n;
    ipl_n = 3'h2;
    rin_n = 1'h1;
    @(negedge mclk);
    chk("sync_hold", {3'h7, 1'h0}, {ipl_s, rsi_n});
    waitv(rsi_n, 1'h1, n);
    chk("sync", {3'h2, 2'h3}, {ipl_s, rsi_n, n >= 3});
  endtask
  task automatic t_xfer(input logic w, input logic [1:0] k, input logic e, input logic [31:0] v);
    int n;
    req = '{addr: v ^ 32'h5a5a_0000, wdata: v, write: w, size: k, ttype: k, space: {k[0], k}};
    waits = {2'h0, k};
    err_i = e;
    ackd = w;
    rd = ~v;
    vld = 1'h1;
    waitv(st_n, 1'h0, n);
    vld = 1'h0;
    chk("phase", bcps_pkg::PHASE_FOURTH, ph);
    chk("addr", req.addr, addr);
    chk("ctl", {w, k, k, k[0], k, !w, 1'h0}, {wr, size, ttype, space, doe_n, aoe_n});
    chk("tip", {4'h0, !ackd, !ackd}, {tip_n, tip_oe_n, bb_n, bb_oe_n, ta_n, ta_oe_n});
    if (w) chk("data", v, data);
    waitv(done, 1'h1, n);
    ackd = 1'h0;
    chk("wait", 1'h1, n >= 4 * k);
    chk("error", e, err);
    if (!w && !e) chk("rdata", ~v, rdata);
    waitv(tip_oe_n, 1'h1, n);
    chk("float", {bcps_pkg::PHASE_FIRST, 6'h3f}, {ph, tip_n, bb_n, bb_oe_n, ta_n, ta_oe_n, doe_n});
    waitv(rdy, 1'h1, n);
  endtask
  initial begin
    rst_n = 1'h0;
    vld = 1'h0;
    req = '0;
    ipl_n = 3'h7;
    rin_n = 1'h0;
    waits = 4'h0;
    err_i = 1'h0;
    ackd = 1'h0;
    rd = 32'h0;
    div = 2'h0;
    repeat (5) @(negedge mclk);
    chk("rst_strb", 9'h1ff, {st_n, tip_n, tip_oe_n, ta_n, ta_oe_n, bb_n, bb_oe_n, aoe_n, doe_n});
    chk("rst_addr", bcps_pkg::ADDR_RST, addr);
    chk("rst_sync", {bcps_pkg::PHASE_FIRST, bcps_pkg::IPL_RST, 2'h0}, {ph, ipl_s, rsi_n, rdy});
    repeat (5) @(negedge mclk);
    rst_n = 1'h1;
    t_sync();
    for (int i = 0; i < 4; i++) t_xfer(!i[0], i[1:0], i == 3, 32'h1234_0000 + i * 32'h111);
    end_sim();
  end
endmodule
`default_nettype wire
